/* hw/icsl_top.sv */
/*
 Map-stage slotting of a four-slot line and latency-timed issue to pipes.
 Assumes one renamed line at a time and fills that follow load misses.
*/
`timescale 1ns/100ps
// Overview of operation
// RQ1 - At map time each either-class instruction gets upper or lower pair.
// RQ2 - Classes upper-only, lower-only, either; only either is chosen.
// RQ3 - Lower-only instructions always go to a lower pair.
// RQ4 - Upper-only instructions always go to an upper pair.
// RQ5 - Slot position 0 to 3 comes from PC bits 3 down to 2.
// RQ6 - Each four-slot class pattern maps to a fixed upper/lower pattern.
// RQ7 - Issue only when operands and the needed pipe are free.
// RQ8 - Only producer-to-consumer and pipe conflicts are tracked at issue.
// RQ9 - Every class has a fixed latency except loads missing the cache.
// RQ10 - Load hits take 3 or 4 cycles; misses 13 or 14 plus.
// RQ11 - Stores, conditional branches, register writes produce no result.
// RQ12 - Cycle-counter reads take one cycle, one more across clusters.
// RQ13 - Add, logic, shift, second move half take one cycle, plus cross.
// RQ14 - Internal register reads take one or three cycles by owning unit.
// RQ15 - Unconditional branches report three cycles, write no result.
// RQ16 - First move half takes one cycle, consumed by its second half.
// RQ17 - Float add takes four cycles, six to float stores or moves.
// RQ18 - The six cycles run from float add issue to consumer issue.
// RQ19 - One pair select per slot, held until the instruction issues.
module icsl_top #(
	parameter logic [icsl_pkg::LAT_W-1:0] BCACHE_EXTRA = 5'h00
) (
	input  wire logic                            clk,
	input  wire logic                            resetn,
	input  wire logic                            line_valid,
	output logic                                 line_ready,
	input  wire icsl_pkg::icsl_entry_t [3:0]     lane,
	input  wire logic [1:0]                      pipe_busy,
	input  wire logic                            ld_miss,
	input  wire logic [icsl_pkg::TAG_W-1:0]      ld_miss_tag,
	input  wire logic                            ld_fill,
	input  wire logic [icsl_pkg::TAG_W-1:0]      ld_fill_tag,
	output logic [3:0]                           slot_upper,
	output logic [3:0]                           issue_valid,
	output logic [3:0][icsl_pkg::LAT_W-1:0]      issue_latency
);
	localparam int NTAG = 2 ** icsl_pkg::TAG_W;

	icsl_pkg::icsl_entry_t [3:0]      win;
	icsl_pkg::icsl_entry_t [3:0]      next_win;
	icsl_pkg::icsl_score_t [NTAG-1:0] sb;
	icsl_pkg::icsl_score_t [NTAG-1:0] next_sb;
	logic                             next_line_ready;
	logic [3:0]                       issue_now;
	logic [3:0]                       next_issue_valid;
	logic [3:0][icsl_pkg::LAT_W-1:0]  next_issue_latency;
	logic                             accept;

	icsl_slot_if sif ();

	icsl_slot_map u_slot_map (
		.clk    (clk),
		.resetn (resetn),
		.sif    (sif)
	);

	// Slot index of an instruction from its PC
	function automatic logic [1:0] slot_idx(
		input logic [icsl_pkg::PC_W-1:0] pc
	);
		return pc[icsl_pkg::PC_SLOT_HI:icsl_pkg::PC_SLOT_LO]; // RQ5
	endfunction : slot_idx

	// Fixed latency reported for each class
	function automatic logic [icsl_pkg::LAT_W-1:0] lat_of(
		input icsl_pkg::icsl_op_t op,
		input logic               ipr_slow
	);
		logic [icsl_pkg::LAT_W-1:0] l;
		l = icsl_pkg::LAT_NONE;
		case (op) // RQ9
		icsl_pkg::OP_ILD:        l = icsl_pkg::LAT_ILD_HIT; // RQ10
		icsl_pkg::OP_FLD:        l = icsl_pkg::LAT_FLD_HIT; // RQ10
		icsl_pkg::OP_RPCC:       l = icsl_pkg::LAT_RPCC; // RQ12
		icsl_pkg::OP_RX:         l = icsl_pkg::LAT_RX;
		icsl_pkg::OP_IREG_RD:    l = ipr_slow ? icsl_pkg::LAT_IPR_SLOW
			: icsl_pkg::LAT_IPR_FAST; // RQ14
		icsl_pkg::OP_UBR:        l = icsl_pkg::LAT_UBR; // RQ15
		icsl_pkg::OP_JSR:        l = icsl_pkg::LAT_JSR;
		icsl_pkg::OP_IADD,
		icsl_pkg::OP_ILOG,
		icsl_pkg::OP_ISHF,
		icsl_pkg::OP_CMOV_SECOND: l = icsl_pkg::LAT_INT; // RQ13
		icsl_pkg::OP_CMOV_FIRST: l = icsl_pkg::LAT_CMOV_FIRST; // RQ16
		icsl_pkg::OP_IMUL:       l = icsl_pkg::LAT_IMUL;
		icsl_pkg::OP_IMISC:      l = icsl_pkg::LAT_IMISC;
		icsl_pkg::OP_FADD:       l = icsl_pkg::LAT_FADD; // RQ17
		default:                 l = icsl_pkg::LAT_NONE; // RQ11
		endcase
		return l;
	endfunction : lat_of

	// Classes whose result a consumer waits on
	function automatic logic writes_reg(input icsl_pkg::icsl_op_t op);
		return (lat_of(op, 1'b0) != icsl_pkg::LAT_NONE) &&
			(op != icsl_pkg::OP_UBR); // RQ11 RQ15
	endfunction : writes_reg

	// Classes that pay one more cycle across clusters
	function automatic logic cross_of(input icsl_pkg::icsl_op_t op);
		return op inside {icsl_pkg::OP_RPCC, icsl_pkg::OP_IADD,
			icsl_pkg::OP_ILOG, icsl_pkg::OP_ISHF,
			icsl_pkg::OP_CMOV_FIRST, icsl_pkg::OP_CMOV_SECOND,
			icsl_pkg::OP_IMUL, icsl_pkg::OP_IMISC}; // RQ12 RQ13
	endfunction : cross_of

	// Producer ready for this consumer in the cycle of the check
	function automatic logic src_ready(
		input icsl_pkg::icsl_score_t s,
		input logic                  up,
		input logic                  fst_use
	);
		logic [icsl_pkg::LAT_W:0] need;
		need = {1'b0, s.base};
		if (s.xc && (s.up != up)) begin
			need = need + {1'b0, icsl_pkg::LAT_XCLUSTER}; // RQ12 RQ13
		end
		if (s.fpl && fst_use) begin
			need = need + {1'b0, 5'(icsl_pkg::LAT_FADD_FST
				- icsl_pkg::LAT_FADD)}; // RQ17 RQ18
		end
		return !s.pend && (({1'b0, s.age} + 6'h01) >= need);
	endfunction : src_ready

	// Source tag a or b of an entry
	function automatic logic [icsl_pkg::TAG_W-1:0] src_of(
		input icsl_pkg::icsl_entry_t e,
		input int                    b
	);
		return (b == 0) ? e.src_a : e.src_b;
	endfunction : src_of

	// Line hand-off and slot pattern for the map
	always_comb begin
		accept  = line_valid && line_ready;
		sif.load = accept;
		for (int s = 0; s < 4; s++) begin
			sif.pattern[s] = icsl_pkg::SC_EITHER;
		end
		for (int k = 0; k < 4; k++) begin
			if (lane[k].valid) begin
				sif.pattern[slot_idx(lane[k].pc)] = lane[k].cls; // RQ5
			end
		end
	end

	// Issue pick, oldest slot first, one per pipe
	always_comb begin
		logic [1:0] used;
		logic       ok;
		logic [icsl_pkg::TAG_W-1:0] t;
		used = 2'h0;
		ok   = 1'b0;
		t    = '0;
		issue_now = 4'h0;
		for (int s = 0; s < 4; s++) begin
			ok = win[s].valid && !pipe_busy[sif.upper[s]] &&
				!used[sif.upper[s]]; // RQ7
			for (int b = 0; b < 2; b++) begin
				t = src_of(win[s], b);
				if (win[s].src_en[b]) begin
					ok = ok && src_ready(sb[t], sif.upper[s],
						win[s].fst_use); // RQ7 RQ8
					for (int j = 0; j < s; j++) begin
						if (win[j].valid && win[j].dst_en &&
							writes_reg(win[j].op) && win[j].dst == t) begin
							ok = 1'b0; // RQ8
						end
					end
				end
			end
			if (ok) begin
				issue_now[s]        = 1'b1;
				used[sif.upper[s]]  = 1'b1;
			end
		end
	end

	// Window: filled by slot position, emptied by issue
	always_comb begin
		next_win = win;
		for (int s = 0; s < 4; s++) begin
			if (issue_now[s]) begin
				next_win[s].valid = 1'b0; // RQ19
			end
		end
		if (accept) begin
			for (int k = 0; k < 4; k++) begin
				if (lane[k].valid) begin
					next_win[slot_idx(lane[k].pc)] = lane[k]; // RQ5
				end
			end
		end
		next_line_ready = 1'b1;
		for (int s = 0; s < 4; s++) begin
			next_line_ready = next_line_ready && !next_win[s].valid;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			win        <= {4{icsl_pkg::ENTRY_RST}};
			line_ready <= icsl_pkg::READY_RST;
		end else begin
			win        <= next_win;
			line_ready <= next_line_ready;
		end
	end

	// Issue strobes with the class latency
	always_comb begin
		next_issue_valid = issue_now;
		for (int s = 0; s < 4; s++) begin
			next_issue_latency[s] = issue_now[s]
				? lat_of(win[s].op, win[s].ipr_slow) // RQ9
				: icsl_pkg::LAT_NONE;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			issue_valid   <= 4'h0;
			issue_latency <= {4{icsl_pkg::LAT_NONE}};
		end else begin
			issue_valid   <= next_issue_valid;
			issue_latency <= next_issue_latency;
		end
	end

	// Per-tag producer timing; miss set wins over fill
	always_comb begin
		next_sb = sb;
		for (int t = 0; t < NTAG; t++) begin
			if (sb[t].age != icsl_pkg::AGE_MAX) begin
				next_sb[t].age = sb[t].age + 5'h01;
			end
		end
		for (int s = 0; s < 4; s++) begin
			if (issue_now[s] && win[s].dst_en && writes_reg(win[s].op)) begin
				next_sb[win[s].dst] = '{pend: 1'b0,
					xc:   cross_of(win[s].op),
					fpl:  win[s].op == icsl_pkg::OP_FADD, // RQ18
					up:   sif.upper[s],
					base: lat_of(win[s].op, win[s].ipr_slow),
					age:  icsl_pkg::AGE_ZERO};
			end
		end
		if (ld_fill) begin
			next_sb[ld_fill_tag].pend = 1'b0;
		end
		if (ld_miss) begin
			next_sb[ld_miss_tag].pend = 1'b1; // RQ10
			next_sb[ld_miss_tag].base =
				(sb[ld_miss_tag].base == icsl_pkg::LAT_FLD_HIT)
				? 5'(icsl_pkg::LAT_FLD_MISS + BCACHE_EXTRA)
				: 5'(icsl_pkg::LAT_ILD_MISS + BCACHE_EXTRA); // RQ10
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sb <= {NTAG{icsl_pkg::SCORE_RST}};
		end else begin
			sb <= next_sb;
		end
	end

	assign slot_upper = sif.upper; // RQ19

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	chk_slot_from_pc: assert property ( // RQ5
		accept && lane[0].valid
		|=> win[$past(slot_idx(lane[0].pc))].op == $past(lane[0].op))
		else $error("lane not placed at its PC slot");
	chk_one_per_pipe: assert property ( // RQ7
		$countones(issue_valid & slot_upper) <= 1 &&
		$countones(issue_valid & ~slot_upper) <= 1)
		else $error("two issues to one pipe in a cycle");
	chk_busy_pipe: assert property ( // RQ7
		|(issue_valid & slot_upper) |-> !$past(pipe_busy[1]))
		else $error("issue to a busy upper pipe");
	chk_hold_select: assert property ( // RQ19
		|{win[3].valid, win[2].valid, win[1].valid, win[0].valid}
		|=> $stable(slot_upper))
		else $error("pair select changed before issue");
	chk_miss_pend: assert property ( // RQ10
		ld_miss |=> sb[$past(ld_miss_tag)].pend)
		else $error("missed load tag not held");

	for (genvar g = 0; g < 4; g++) begin : g_chk
		chk_lat_loads: assert property ( // RQ10
			issue_valid[g] && win[g].op == icsl_pkg::OP_ILD
			|-> issue_latency[g] == 5'h03)
			else $error("integer load hit latency wrong");
		chk_lat_int: assert property ( // RQ13
			issue_valid[g] && win[g].op inside {icsl_pkg::OP_IADD,
			icsl_pkg::OP_ILOG, icsl_pkg::OP_ISHF}
			|-> issue_latency[g] == 5'h01)
			else $error("integer operate latency wrong");
		chk_no_result: assert property ( // RQ11
			issue_valid[g] && win[g].op inside {icsl_pkg::OP_IST,
			icsl_pkg::OP_FST, icsl_pkg::OP_ICBR, icsl_pkg::OP_IREG_WR}
			|-> issue_latency[g] == 5'h00)
			else $error("no-result class reported a latency");
		chk_lat_ubr: assert property ( // RQ15
			issue_valid[g] && win[g].op == icsl_pkg::OP_UBR
			|-> issue_latency[g] == 5'h03)
			else $error("unconditional branch latency wrong");
		chk_fadd_store: assert property ( // RQ17
			issue_valid[g] && win[g].fst_use && win[g].src_en[0] &&
			$past(sb[win[g].src_a].fpl)
			|-> $past(sb[win[g].src_a].age) + 1 >= 6)
			else $error("float store issued before six cycles");
	end

	cov_dual_issue: cover property ($countones(issue_valid) == 2);
	cov_miss_fill: cover property (ld_miss ##[1:40] ld_fill);
	cov_line_taken: cover property (accept ##1 !line_ready);

endmodule : icsl_top

/* hw/icsl_pkg.sv */
/*
 Shared types and constants of the integer slotting and latency block.
 Assumes renamed register tags of TAG_W bits from the rename stage.
*/
package icsl_pkg;

	// Line shape and field positions
	localparam int SLOTS      = 4;
	localparam int TAG_W      = 3;
	localparam int LAT_W      = 5;
	localparam int PC_W       = 4;
	localparam int PC_SLOT_HI = 3;
	localparam int PC_SLOT_LO = 2;

	// Slot classes: either, lower-only, upper-only
	typedef enum logic [1:0] {
		SC_EITHER = 2'h0,
		SC_LOWER  = 2'h1,
		SC_UPPER  = 2'h2
	} icsl_slot_class_t;

	// Instruction classes as seen by the issue timing
	typedef enum logic [4:0] {
		OP_ILD         = 5'h00,
		OP_FLD         = 5'h01,
		OP_IST         = 5'h02,
		OP_FST         = 5'h03,
		OP_RPCC        = 5'h04,
		OP_RX          = 5'h05,
		OP_IREG_RD     = 5'h06,
		OP_IREG_WR     = 5'h07,
		OP_ICBR        = 5'h08,
		OP_UBR         = 5'h09,
		OP_JSR         = 5'h0a,
		OP_IADD        = 5'h0b,
		OP_ILOG        = 5'h0c,
		OP_ISHF        = 5'h0d,
		OP_CMOV_FIRST  = 5'h0e,
		OP_CMOV_SECOND = 5'h0f,
		OP_IMUL        = 5'h10,
		OP_IMISC       = 5'h11,
		OP_FCBR        = 5'h12,
		OP_FADD        = 5'h13
	} icsl_op_t;

	// One renamed instruction of the fetch line
	typedef struct packed {
		logic                valid;
		icsl_slot_class_t    cls;
		logic [PC_W-1:0]     pc;
		icsl_op_t            op;
		logic                ipr_slow;
		logic                fst_use;
		logic                dst_en;
		logic [TAG_W-1:0]    dst;
		logic [1:0]          src_en;
		logic [TAG_W-1:0]    src_a;
		logic [TAG_W-1:0]    src_b;
	} icsl_entry_t;

	// Producer timing kept per tag
	typedef struct packed {
		logic                pend;
		logic                xc;
		logic                fpl;
		logic                up;
		logic [LAT_W-1:0]    base;
		logic [LAT_W-1:0]    age;
	} icsl_score_t;

	// Result latencies in core cycles
	localparam logic [LAT_W-1:0] LAT_NONE       = 5'h00;
	localparam logic [LAT_W-1:0] LAT_ILD_HIT    = 5'h03;
	localparam logic [LAT_W-1:0] LAT_FLD_HIT    = 5'h04;
	localparam logic [LAT_W-1:0] LAT_ILD_MISS   = 5'h0d;
	localparam logic [LAT_W-1:0] LAT_FLD_MISS   = 5'h0e;
	localparam logic [LAT_W-1:0] LAT_RPCC       = 5'h01;
	localparam logic [LAT_W-1:0] LAT_RX         = 5'h01;
	localparam logic [LAT_W-1:0] LAT_IPR_FAST   = 5'h01;
	localparam logic [LAT_W-1:0] LAT_IPR_SLOW   = 5'h03;
	localparam logic [LAT_W-1:0] LAT_UBR        = 5'h03;
	localparam logic [LAT_W-1:0] LAT_JSR        = 5'h03;
	localparam logic [LAT_W-1:0] LAT_INT        = 5'h01;
	localparam logic [LAT_W-1:0] LAT_CMOV_FIRST = 5'h01;
	localparam logic [LAT_W-1:0] LAT_IMUL       = 5'h07;
	localparam logic [LAT_W-1:0] LAT_IMISC      = 5'h03;
	localparam logic [LAT_W-1:0] LAT_FADD       = 5'h04;
	localparam logic [LAT_W-1:0] LAT_FADD_FST   = 5'h06;
	localparam logic [LAT_W-1:0] LAT_XCLUSTER   = 5'h01;
	localparam logic [LAT_W-1:0] AGE_ZERO       = 5'h00;
	localparam logic [LAT_W-1:0] AGE_MAX        = 5'h1f;

	// Reset values
	localparam icsl_entry_t ENTRY_RST = '0;
	localparam icsl_score_t SCORE_RST = '{1'b0, 1'b0, 1'b0, 1'b0,
		5'h00, 5'h1f};
	localparam logic        READY_RST = 1'b1;

endpackage : icsl_pkg

/* hw/icsl_slot_if.sv */
/*
 Carrier between the line control and the slot map.
 Assumes both ends run on the one core clock.
*/
`timescale 1ns/100ps
interface icsl_slot_if;
	logic                             load;
	icsl_pkg::icsl_slot_class_t [3:0] pattern;
	logic [3:0]                       upper;

	modport ctrl (output load, output pattern, input upper);
	modport map (input load, input pattern, output upper);
endinterface : icsl_slot_if

/* hw/icsl_slot_map.sv */
/*
 Slot map: turns the four slot classes of a line into upper/lower selects.
 Assumes load pulses only while the previous line has fully issued.
*/
`timescale 1ns/100ps
module icsl_slot_map (
	input wire logic    clk,
	input wire logic    resetn,
	icsl_slot_if.map    sif
);
	localparam icsl_pkg::icsl_slot_class_t CE = icsl_pkg::SC_EITHER;
	localparam icsl_pkg::icsl_slot_class_t CL = icsl_pkg::SC_LOWER;
	localparam icsl_pkg::icsl_slot_class_t CU = icsl_pkg::SC_UPPER;

	logic [3:0] upper;
	logic [3:0] next_upper;
	logic [3:0] low_mask;
	logic [3:0] up_mask;

	// Select per slot, bit set means upper pair; slot 3 is the MSB
	function automatic logic [3:0] slot_of(
		input icsl_pkg::icsl_slot_class_t [3:0] p
	);
		logic [3:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i] = (p[i] == CU); // RQ3 RQ4
		end
		case (p) // RQ2 RQ6
		{CE,CE,CE,CE}: r = 4'ha;
		{CE,CE,CE,CL}: r = 4'ha;
		{CE,CE,CE,CU}: r = 4'h9;
		{CE,CE,CL,CE}: r = 4'h9;
		{CE,CE,CL,CL}: r = 4'hc;
		{CE,CE,CL,CU}: r = 4'h9;
		{CE,CE,CU,CE}: r = 4'ha;
		{CE,CE,CU,CL}: r = 4'ha;
		{CE,CE,CU,CU}: r = 4'h3;
		{CE,CL,CE,CE}: r = 4'ha;
		{CE,CL,CE,CL}: r = 4'ha;
		{CE,CL,CE,CU}: r = 4'h9;
		{CE,CL,CL,CE}: r = 4'h9;
		{CE,CL,CL,CL}: r = 4'h8;
		{CE,CL,CL,CU}: r = 4'h9;
		{CE,CL,CU,CE}: r = 4'ha;
		{CE,CL,CU,CL}: r = 4'ha;
		{CE,CL,CU,CU}: r = 4'h3;
		{CE,CU,CE,CE}: r = 4'h5;
		{CE,CU,CE,CL}: r = 4'h6;
		{CE,CU,CE,CU}: r = 4'h5;
		{CE,CU,CL,CE}: r = 4'h5;
		{CE,CU,CL,CL}: r = 4'hc;
		{CE,CU,CL,CU}: r = 4'h5;
		{CE,CU,CU,CE}: r = 4'h6;
		{CE,CU,CU,CL}: r = 4'h6;
		{CE,CU,CU,CU}: r = 4'h7;
		{CL,CE,CE,CE}: r = 4'h5;
		{CL,CE,CE,CL}: r = 4'h6;
		{CL,CE,CE,CU}: r = 4'h5;
		{CL,CE,CL,CE}: r = 4'h5;
		{CL,CE,CL,CL}: r = 4'h4;
		{CL,CE,CL,CU}: r = 4'h5;
		{CL,CE,CU,CE}: r = 4'h6;
		{CL,CE,CU,CL}: r = 4'h6;
		{CL,CE,CU,CU}: r = 4'h3;
		{CL,CL,CE,CE}: r = 4'h3;
		{CL,CL,CE,CL}: r = 4'h2;
		{CL,CL,CE,CU}: r = 4'h3;
		{CL,CL,CL,CE}: r = 4'h1;
		{CL,CL,CU,CE}: r = 4'h3;
		{CL,CU,CE,CE}: r = 4'h5;
		{CL,CU,CE,CL}: r = 4'h6;
		{CL,CU,CE,CU}: r = 4'h5;
		{CL,CU,CL,CE}: r = 4'h5;
		{CL,CU,CU,CE}: r = 4'h6;
		{CU,CE,CE,CE}: r = 4'ha;
		{CU,CE,CE,CL}: r = 4'ha;
		{CU,CE,CE,CU}: r = 4'h9;
		{CU,CE,CL,CE}: r = 4'h9;
		{CU,CE,CL,CL}: r = 4'hc;
		{CU,CE,CL,CU}: r = 4'h9;
		{CU,CE,CU,CE}: r = 4'ha;
		{CU,CE,CU,CL}: r = 4'ha;
		{CU,CE,CU,CU}: r = 4'hb;
		{CU,CL,CE,CE}: r = 4'ha;
		{CU,CL,CE,CL}: r = 4'ha;
		{CU,CL,CE,CU}: r = 4'h9;
		{CU,CL,CL,CE}: r = 4'h9;
		{CU,CL,CU,CE}: r = 4'ha;
		{CU,CU,CE,CE}: r = 4'hc;
		{CU,CU,CE,CL}: r = 4'hc;
		{CU,CU,CE,CU}: r = 4'hd;
		{CU,CU,CL,CE}: r = 4'hc;
		{CU,CU,CU,CE}: r = 4'he;
		default:       r = r;
		endcase
		return r;
	endfunction : slot_of

	// Choose on load, otherwise hold until the line has issued
	always_comb begin
		next_upper = sif.load ? slot_of(sif.pattern) : upper; // RQ1 RQ19
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			upper <= 4'h0;
		end else begin
			upper <= next_upper;
		end
	end

	assign sif.upper = upper;

	// Masks of fixed-pair slots, for checking only
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			low_mask[i] = (sif.pattern[i] == CL);
			up_mask[i]  = (sif.pattern[i] == CU);
		end
	end

	chk_lower_kept: assert property (@(posedge clk) disable iff (!resetn) // RQ3
		sif.load |=> (upper & $past(low_mask)) == 4'h0)
		else $error("lower-only slot sent to upper pair");
	chk_upper_kept: assert property (@(posedge clk) disable iff (!resetn) // RQ4
		sif.load |=> (upper & $past(up_mask)) == $past(up_mask))
		else $error("upper-only slot sent to lower pair");
	chk_eeee_spread: assert property (@(posedge clk) disable iff (!resetn) // RQ6
		sif.load && sif.pattern == {CE, CE, CE, CE} |=> upper == 4'ha)
		else $error("all-either line not spread alternately");
	chk_fixed_pass: assert property (@(posedge clk) disable iff (!resetn) // RQ2
		sif.load && ((low_mask | up_mask) == 4'hf)
		|=> upper == $past(up_mask))
		else $error("line without either slots was altered");
	cov_all_either: cover property (@(posedge clk) disable iff (!resetn)
		sif.load && sif.pattern == {CE, CE, CE, CE});

endmodule : icsl_slot_map

/* test/icsl_front_model.sv */
/*
 Front end model: offers one renamed line and holds it until taken.
 Assumes the block samples line_valid and lane at the rising clock edge.
*/
`timescale 1ns/100ps
module icsl_front_model (
	input  wire logic                   clk,
	input  wire logic                   line_ready,
	output logic                        line_valid,
	output icsl_pkg::icsl_entry_t [3:0] lane
);
	// Idle until the first offer
	initial begin
		line_valid = 1'b0;
		lane       = '0;
	end

	// Offer a line and hold it until taken
	task automatic offer(input icsl_pkg::icsl_entry_t [3:0] l);
		int n;
		@(negedge clk);
		lane       = l;
		line_valid = 1'b1;
		n          = 0;
		while (line_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		line_valid = 1'b0;
		lane       = ~l; // Inverted while idle
	endtask : offer
endmodule : icsl_front_model

/* test/tb_icsl_top.sv */
/*
 Self-checking bench of the slotting and latency block.
 Assumes a 40 MHz core clock and inputs driven at the falling edge.
*/
`timescale 1ns/100ps
module tb_icsl_top;
	logic                              clk;
	logic                              resetn;
	logic                              line_valid;
	logic                              line_ready;
	icsl_pkg::icsl_entry_t [3:0]       lane;
	logic [1:0]                        pipe_busy;
	logic                              ld_miss;
	logic                              ld_fill;
	logic [icsl_pkg::TAG_W-1:0]        ld_miss_tag;
	logic [icsl_pkg::TAG_W-1:0]        ld_fill_tag;
	logic [3:0]                        slot_upper;
	logic [3:0]                        issue_valid;
	logic [3:0][icsl_pkg::LAT_W-1:0]   issue_latency;
	logic [icsl_pkg::LAT_W-1:0]        lat0;
	int                                err_count;
	int                                checked;
	int                                cyc;

	icsl_top i_icsl_top (.clk(clk), .resetn(resetn), .line_valid(line_valid),
		.line_ready(line_ready), .lane(lane), .pipe_busy(pipe_busy),
		.ld_miss(ld_miss), .ld_miss_tag(ld_miss_tag), .ld_fill(ld_fill),
		.ld_fill_tag(ld_fill_tag), .slot_upper(slot_upper),
		.issue_valid(issue_valid), .issue_latency(issue_latency));

	icsl_front_model i_icsl_front_model (.clk(clk), .line_ready(line_ready),
		.line_valid(line_valid), .lane(lane));

	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Cycle count and hang limit
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic cmp4(input string n, input logic [3:0] e, input logic [3:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp4

	task automatic cmp5(input string n, input logic [4:0] e, input logic [4:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp5

	task automatic cmp_gap(input string n, input int e, input int g);
		checked++;
		if (g != e) begin
			err_count++;
			$display("unexpected %s expected %0d seen %0d", n, e, g);
		end
	endtask : cmp_gap

	// One valid lane at slot s
	function automatic icsl_pkg::icsl_entry_t mk(input logic [1:0] s,
		input icsl_pkg::icsl_slot_class_t c, input icsl_pkg::icsl_op_t o,
		input logic de, input logic [1:0] se, input logic fst,
		input logic slow, input logic [2:0] t);
		icsl_pkg::icsl_entry_t e;
		e          = '0;
		e.valid    = 1'b1;
		e.cls      = c;
		e.pc       = {s, 2'h0};
		e.op       = o;
		e.dst_en   = de;
		e.dst      = t;
		e.src_en   = se;
		e.src_a    = t;
		e.fst_use  = fst;
		e.ipr_slow = slow;
		return e;
	endfunction : mk

	// Wait for the slots in m to issue; note cycles of slots 0 and 1
	task automatic wait_pair(input logic [3:0] m, output int t0, output int t1);
		logic [3:0] seen;
		seen = 4'h0;
		t0   = 0;
		t1   = 0;
		for (int n = 0; n < 60 && (seen & m) != m; n++) begin
			@(negedge clk);
			for (int k = 0; k < 4; k++) begin
				if (issue_valid[k] === 1'b1 && !seen[k]) begin
					seen[k] = 1'b1;
					if (k == 0) begin
						t0   = cyc;
						lat0 = issue_latency[0];
					end
					if (k == 1)
						t1 = cyc;
				end
			end
		end
		cmp4("issue_seen", m, seen & m);
	endtask : wait_pair

	task automatic t_reset;
		cmp4("line_ready", 4'h1, {3'h0, line_ready});
		cmp4("slot_upper", 4'h0, slot_upper);
		cmp4("issue_valid", 4'h0, issue_valid);
	endtask : t_reset

	// Class patterns per slot (slot 3 high), lanes in reverse slot order
	task automatic t_slots;
		logic [7:0] pat [10] = '{8'h00, 8'h0a, 8'h05, 8'h55, 8'haa, 8'h20,
			8'h58, 8'h15, 8'ha8, 8'h61};
		logic [3:0] exp [10] = '{4'ha, 4'h3, 4'hc, 4'h0, 4'hf, 4'h5,
			4'h3, 4'h8, 4'he, 4'h6};
		icsl_pkg::icsl_entry_t [3:0] l;
		for (int i = 0; i < 10; i++) begin
			for (int k = 0; k < 4; k++)
				l[k] = mk(2'(3 - k), icsl_pkg::icsl_slot_class_t'(
					pat[i][2*(3-k)+:2]), icsl_pkg::OP_IADD, 1'b0, 2'h0,
					1'b0, 1'b0, 3'h0);
			i_icsl_front_model.offer(l);
			cmp4("slot_upper", exp[i], slot_upper);
			repeat (5) @(negedge clk);
			cmp4("slot_upper_held", exp[i], slot_upper);
		end
	endtask : t_slots

	// Latency reported with each issue
	task automatic t_lat;
		icsl_pkg::icsl_op_t op [13] = '{icsl_pkg::OP_ILD, icsl_pkg::OP_FLD,
			icsl_pkg::OP_IST, icsl_pkg::OP_FST, icsl_pkg::OP_RPCC,
			icsl_pkg::OP_IREG_RD, icsl_pkg::OP_IREG_RD, icsl_pkg::OP_IREG_WR,
			icsl_pkg::OP_ICBR, icsl_pkg::OP_UBR, icsl_pkg::OP_IADD,
			icsl_pkg::OP_CMOV_FIRST, icsl_pkg::OP_FADD};
		logic slow [13] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
		logic [4:0] exp [13] = '{5'h03, 5'h04, 5'h00, 5'h00, 5'h01, 5'h01,
			5'h03, 5'h00, 5'h00, 5'h03, 5'h01, 5'h01, 5'h04};
		icsl_pkg::icsl_entry_t [3:0] l;
		int t0;
		int t1;
		for (int i = 0; i < 13; i++) begin
			l    = '0;
			l[0] = mk(2'h0, icsl_pkg::SC_EITHER, op[i], 1'b0, 2'h0, 1'b0,
				slow[i], 3'h0);
			i_icsl_front_model.offer(l);
			wait_pair(4'h1, t0, t1);
			cmp5("issue_latency", exp[i], lat0);
		end
	endtask : t_lat

	// Producer in slot 0, consumer of its tag in slot 1
	task automatic t_dep(input icsl_pkg::icsl_op_t p, input icsl_pkg::icsl_op_t c,
		input icsl_pkg::icsl_slot_class_t c0, input icsl_pkg::icsl_slot_class_t c1,
		input logic fst, input int gap);
		icsl_pkg::icsl_entry_t [3:0] l;
		int t0;
		int t1;
		l    = '0;
		l[0] = mk(2'h0, c0, p, 1'b1, 2'h0, 1'b0, 1'b0, 3'h2);
		l[1] = mk(2'h1, c1, c, 1'b0, 2'h1, fst, 1'b0, 3'h2);
		i_icsl_front_model.offer(l);
		wait_pair(4'h3, t0, t1);
		cmp_gap("issue_gap", gap, t1 - t0);
	endtask : t_dep

	// Load miss holds its consumer until the fill
	task automatic t_miss;
		icsl_pkg::icsl_entry_t [3:0] l;
		int t0;
		int t1;
		int early;
		int tf;
		l    = '0;
		l[0] = mk(2'h0, icsl_pkg::SC_LOWER, icsl_pkg::OP_ILD, 1'b1, 2'h0,
			1'b0, 1'b0, 3'h3);
		l[1] = mk(2'h1, icsl_pkg::SC_LOWER, icsl_pkg::OP_IADD, 1'b0, 2'h1,
			1'b0, 1'b0, 3'h3);
		i_icsl_front_model.offer(l);
		wait_pair(4'h1, t0, t1);
		ld_miss     = 1'b1;
		ld_miss_tag = 3'h3;
		early       = 0;
		@(negedge clk);
		ld_miss = 1'b0;
		repeat (20) begin
			@(negedge clk);
			if (issue_valid[1] !== 1'b0)
				early++;
		end
		cmp_gap("consumer_before_fill", 0, early);
		ld_fill     = 1'b1;
		ld_fill_tag = 3'h3;
		tf          = cyc;
		@(negedge clk);
		ld_fill = 1'b0;
		wait_pair(4'h2, t0, t1);
		cmp_gap("fill_to_issue_ok", 1, int'((t1 - tf) inside {[1:3]}));
	endtask : t_miss

	// Busy lower pipe stalls only the lower instruction
	task automatic t_busy;
		icsl_pkg::icsl_entry_t [3:0] l;
		int t0;
		int t1;
		l         = '0;
		l[0]      = mk(2'h0, icsl_pkg::SC_LOWER, icsl_pkg::OP_IADD, 1'b0,
			2'h0, 1'b0, 1'b0, 3'h0);
		l[1]      = mk(2'h1, icsl_pkg::SC_UPPER, icsl_pkg::OP_IADD, 1'b0,
			2'h0, 1'b0, 1'b0, 3'h0);
		pipe_busy = 2'h1;
		i_icsl_front_model.offer(l);
		wait_pair(4'h2, t0, t1);
		repeat (6) @(negedge clk) t0 += int'(issue_valid[0] !== 1'b0);
		cmp_gap("lower_issued_while_busy", 0, t0);
		pipe_busy = 2'h0;
		wait_pair(4'h1, t0, t1);
	endtask : t_busy

	// Main sequence
	initial begin
		err_count   = 0;
		checked     = 0;
		cyc         = 0;
		resetn      = 1'b0;
		pipe_busy   = 2'h0;
		ld_miss     = 1'b0;
		ld_fill     = 1'b0;
		ld_miss_tag = 3'h0;
		ld_fill_tag = 3'h0;
		repeat (16) @(negedge clk);
		t_reset();
		resetn = 1'b1;
		t_slots();
		t_lat();
		t_dep(icsl_pkg::OP_IADD, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_LOWER, 1'b0, 1);
		t_dep(icsl_pkg::OP_IADD, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_UPPER, 1'b0, 2);
		t_dep(icsl_pkg::OP_RPCC, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_UPPER, 1'b0, 2);
		t_dep(icsl_pkg::OP_CMOV_FIRST, icsl_pkg::OP_CMOV_SECOND,
			icsl_pkg::SC_LOWER, icsl_pkg::SC_LOWER, 1'b0, 1);
		t_dep(icsl_pkg::OP_ILD, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_LOWER, 1'b0, 3);
		t_dep(icsl_pkg::OP_FADD, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_LOWER, 1'b0, 4);
		t_dep(icsl_pkg::OP_FADD, icsl_pkg::OP_FST, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_LOWER, 1'b1, 6);
		t_dep(icsl_pkg::OP_UBR, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_UPPER, 1'b0, 0);
		t_dep(icsl_pkg::OP_IST, icsl_pkg::OP_IADD, icsl_pkg::SC_LOWER,
			icsl_pkg::SC_UPPER, 1'b0, 0);
		t_miss();
		t_busy();
		print_verdict();
	end
endmodule : tb_icsl_top
